// ---- logic/one_wire_eprom_command_layer.sv ----
// command layer of a single-wire one-time-programmable eprom slave

// Notes on behaviour
// R1 - reset pulse then presence before any command
// R2 - match command selects only on full identity
// R3 - search: send bit, complement, sample host
// R4 - search mismatch stops driving until reset
// R5 - host reads both-zero slots as collision
// R6 - host restarts search for further devices
// R7 - skip command selects, next byte is memory
// R8 - memory commands ignored unless selected
// R9 - bytes lsb first, address low byte first
// R10 - crc of command and address sent back
// R11 - host resets and retries on crc mismatch
// R12 - page read streams to page end, crc
// R13 - page read continues, 33 bytes per page
// R14 - field read streams to field end, crc
// R15 - ones after field crc; early reset no crc
// R16 - write command echoes crc of command, address
// R17 - eight data bytes buffered, their crc sent
// R18 - host sends program code and long pulse
// R19 - programming ands buffer into eight eprom bytes
// R20 - host write address aligned to eight
// R21 - reset ignored while programming pulse applied
// R22 - programmed bytes returned lsb first
// R23 - crc polynomial x8 + x5 + x4 + 1
// R24 - six pages of 32 bytes, 0000 to 00BF
// R25 - reset abandons command, deselects, drops buffer
// R26 - unprogrammed bits read as ones
module one_wire_eprom_command_layer import link_pkg::*; #(
  parameter logic [63:0] DEVICE_ID = DEFAULT_ID,
  parameter int RESET_CYCLES_P = RESET_CYCLES,
  parameter int PROG_CYCLES_P = PROG_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // line level and slot events from the slot layer
  input wire logic line_level,
  input wire slot_in_t slot,
  input wire logic presence_done,
  input wire logic vpp_on,
  // requests to the slot layer
  output logic presence_req,
  output slot_out_t tx,
  // status
  output logic selected
);

  localparam logic [31:0] RESET_LIM = 32'(RESET_CYCLES_P);
  localparam logic [31:0] PROG_LIM = 32'(PROG_CYCLES_P);

  // address lies inside the data field
  function automatic logic in_field(input logic [15:0] a);
    in_field = (a < 16'(FIELD_BYTES));
  endfunction

  // address is the last byte of its page
  function automatic logic page_end(input logic [15:0] a);
    page_end = (a[4:0] == PAGE_LAST);
  endfunction

  state_t state_reg;
  op_t op_reg;
  logic [6:0] cnt_reg;
  logic [7:0] shift_reg;
  logic [15:0] addr_reg;
  logic [31:0] low_cnt_reg;
  logic [31:0] prog_cnt_reg;
  logic [1:0] phase_reg;
  logic [7:0] mem_reg [FIELD_BYTES];
  slot_out_t tx_next;

  logic bus_reset;
  logic slot_go;
  logic rx_bit;
  logic [7:0] rx_byte;
  logic byte_end;
  logic id_bit;
  logic [7:0] rd_idx;
  logic [7:0] rd_byte;
  logic [7:0] wr_idx;
  logic rd_stop;
  logic crc_clr;
  logic crc_en;
  logic crc_bit;
  logic [7:0] crc_nx;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;

  // long low on the line, ended by its rising edge, is a bus reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_reg <= '0;
    end else if (!line_level) begin
      if (low_cnt_reg < RESET_LIM) begin
        low_cnt_reg <= low_cnt_reg + 32'd1;
      end
    end else begin
      low_cnt_reg <= '0;
    end
  end

  // a reset during the programming pulse would corrupt the cells, so it is not honoured
  assign bus_reset = line_level && (low_cnt_reg >= RESET_LIM)
    && (state_reg != ST_WR_PULSE); // see R1, R21

  // while the buffer cannot take a byte, slots of the data phase are held off
  assign slot_go = slot.valid && ((state_reg != ST_WR_DATA) || fifo_in_ready);
  assign rx_bit = slot.bit_val;
  assign rx_byte = {rx_bit, shift_reg[7:1]}; // see R9
  assign byte_end = slot_go && (cnt_reg[2:0] == 3'd7);
  assign id_bit = DEVICE_ID[cnt_reg[5:0]];

  // verify walks the eight bytes just programmed
  assign wr_idx = {addr_reg[7:3], cnt_reg[2:0]};
  assign rd_idx = (state_reg == ST_WR_VERIFY) ? {addr_reg[7:3], cnt_reg[5:3]} : addr_reg[7:0];
  assign rd_byte = in_field({8'h00, rd_idx}) ? mem_reg[rd_idx] : MEM_ERASED; // see R26

  // page reads stop at the page end, both reads stop at the field end
  assign rd_stop = (op_reg == OP_PAGE && page_end(addr_reg))
    || (addr_reg[7:0] == FIELD_LAST); // see R12, R14, R24

  // crc restarts after the address crc byte and each read crc byte
  assign crc_clr = (state_reg == ST_PRESENCE)
    || (byte_end && (state_reg == ST_ADDR_CRC || state_reg == ST_RD_CRC)); // see R13
  assign crc_en = slot_go && (state_reg == ST_MEM_CMD || state_reg == ST_ADDR
    || state_reg == ST_RD_DATA || state_reg == ST_WR_DATA); // see R10, R17
  assign crc_bit = (state_reg == ST_RD_DATA) ? rd_byte[cnt_reg[2:0]] : rx_bit;

  crc8_serial u_crc (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clr(crc_clr),
    .shift_en(crc_en),
    .bit_in(crc_bit),
    .crc(),
    .crc_nx(crc_nx)
  ); // see R23

  // write data waits here until the program pulse has ended
  assign fifo_in_valid = byte_end && (state_reg == ST_WR_DATA); // see R17
  assign fifo_out_ready = (state_reg == ST_WR_APPLY);

  byte_fifo #(
    .WIDTH(8),
    .DEPTH(BUF_BYTES)
  ) u_buf (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .flush(bus_reset),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(rx_byte),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  ); // see R25

  // command sequencing
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      op_reg <= OP_FIELD;
      phase_reg <= '0;
      cnt_reg <= '0;
      selected <= 1'b0;
    end else if (bus_reset) begin
      state_reg <= ST_PRESENCE; // see R1, R25
      phase_reg <= '0;
      cnt_reg <= '0;
      selected <= 1'b0; // see R25
    end else begin
      case (state_reg)
        ST_IDLE: begin
          cnt_reg <= '0;
        end
        ST_PRESENCE: begin
          if (presence_done) begin
            state_reg <= ST_ROM_CMD; // see R1
          end
        end
        ST_ROM_CMD: begin
          if (slot_go) begin
            cnt_reg <= (cnt_reg[2:0] == 3'd7) ? 7'd0 : cnt_reg + 7'd1;
          end
          if (byte_end) begin
            case (rx_byte)
              CMD_MATCH: state_reg <= ST_MATCH;
              CMD_SEARCH: state_reg <= ST_SEARCH;
              CMD_SKIP: begin
                state_reg <= ST_MEM_CMD; // see R7
                selected <= 1'b1;
              end
              default: state_reg <= ST_IGNORE;
            endcase
          end
        end
        ST_MATCH: begin
          if (slot_go) begin
            cnt_reg <= cnt_reg + 7'd1;
            if (rx_bit != id_bit) begin
              state_reg <= ST_IGNORE; // see R2
            end else if (cnt_reg == 7'(ID_BITS - 1)) begin
              state_reg <= ST_MEM_CMD; // see R2
              selected <= 1'b1;
              cnt_reg <= '0;
            end
          end
        end
        ST_SEARCH: begin
          // each identity bit takes three slots: bit, complement, host bit
          if (slot_go && phase_reg != 2'd2) begin
            phase_reg <= phase_reg + 2'd1; // see R3
          end else if (slot_go) begin
            phase_reg <= 2'd0;
            if (rx_bit != id_bit) begin
              state_reg <= ST_IGNORE; // see R4
            end else if (cnt_reg[5:0] == 6'(ID_BITS - 1)) begin
              state_reg <= ST_MEM_CMD; // see R3
              selected <= 1'b1;
              cnt_reg <= '0;
            end else begin
              cnt_reg <= cnt_reg + 7'd1; // see R3
            end
          end
        end
        ST_MEM_CMD: begin
          if (slot_go) begin
            cnt_reg <= (cnt_reg[2:0] == 3'd7) ? 7'd0 : cnt_reg + 7'd1;
          end
          if (byte_end) begin
            state_reg <= ST_ADDR;
            case (rx_byte)
              CMD_READ_PAGE: op_reg <= OP_PAGE; // see R12
              CMD_READ_FIELD: op_reg <= OP_FIELD; // see R14
              CMD_WRITE: op_reg <= OP_WRITE; // see R16
              default: state_reg <= ST_IGNORE;
            endcase
            if (!selected) begin
              state_reg <= ST_IGNORE; // see R8
            end
          end
        end
        ST_ADDR: begin
          if (slot_go) begin
            cnt_reg <= cnt_reg + 7'd1;
            if (cnt_reg == 7'd15) begin
              state_reg <= ST_ADDR_CRC; // see R10
              cnt_reg <= '0;
            end
          end
        end
        ST_ADDR_CRC: begin
          if (slot_go) begin
            cnt_reg <= (cnt_reg[2:0] == 3'd7) ? 7'd0 : cnt_reg + 7'd1;
          end
          if (byte_end) begin
            if (op_reg == OP_WRITE) begin
              state_reg <= ST_WR_DATA; // see R17
            end else if (in_field(addr_reg)) begin
              state_reg <= ST_RD_DATA;
            end else begin
              state_reg <= ST_RD_ONES;
            end
          end
        end
        ST_RD_DATA: begin
          if (slot_go) begin
            cnt_reg <= (cnt_reg[2:0] == 3'd7) ? 7'd0 : cnt_reg + 7'd1;
          end
          if (byte_end && rd_stop) begin
            state_reg <= ST_RD_CRC; // see R12, R14
          end
        end
        ST_RD_CRC: begin
          if (slot_go) begin
            cnt_reg <= (cnt_reg[2:0] == 3'd7) ? 7'd0 : cnt_reg + 7'd1;
          end
          if (byte_end) begin
            if (op_reg == OP_PAGE && in_field(addr_reg)) begin
              state_reg <= ST_RD_DATA; // see R13
            end else begin
              state_reg <= ST_RD_ONES; // see R15
            end
          end
        end
        ST_WR_DATA: begin
          if (slot_go) begin
            cnt_reg <= cnt_reg + 7'd1;
            if (cnt_reg == 7'(BUF_BYTES * 8 - 1)) begin
              state_reg <= ST_WR_CRC; // see R17
              cnt_reg <= '0;
            end
          end
        end
        ST_WR_CRC: begin
          if (slot_go) begin
            cnt_reg <= (cnt_reg[2:0] == 3'd7) ? 7'd0 : cnt_reg + 7'd1;
          end
          if (byte_end) begin
            state_reg <= ST_WR_PROGCMD;
          end
        end
        ST_WR_PROGCMD: begin
          if (slot_go) begin
            cnt_reg <= (cnt_reg[2:0] == 3'd7) ? 7'd0 : cnt_reg + 7'd1;
          end
          if (byte_end) begin
            state_reg <= (rx_byte == CMD_PROGRAM) ? ST_WR_PULSE : ST_IGNORE; // see R18
          end
        end
        ST_WR_PULSE: begin
          // a pulse shorter than the minimum leaves the cells untouched
          if (!vpp_on && prog_cnt_reg != '0) begin
            state_reg <= (prog_cnt_reg >= PROG_LIM) ? ST_WR_APPLY : ST_IGNORE;
            cnt_reg <= '0;
          end
        end
        ST_WR_APPLY: begin
          if (fifo_out_valid) begin
            cnt_reg <= cnt_reg + 7'd1;
            if (cnt_reg[2:0] == 3'd7) begin
              state_reg <= ST_WR_VERIFY; // see R22
              cnt_reg <= '0;
            end
          end
        end
        ST_WR_VERIFY: begin
          if (slot_go) begin
            cnt_reg <= cnt_reg + 7'd1;
            if (cnt_reg == 7'(BUF_BYTES * 8 - 1)) begin
              state_reg <= ST_RD_ONES;
            end
          end
        end
        ST_RD_ONES, ST_IGNORE: begin
          cnt_reg <= '0;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // receive shifting, crc capture and the address pointer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= '0;
      addr_reg <= '0;
    end else begin
      if (slot_go && state_reg == ST_ADDR) begin
        addr_reg <= {rx_bit, addr_reg[15:1]}; // see R9
        if (cnt_reg == 7'd15) begin
          shift_reg <= crc_nx; // see R10, R16
        end
      end else if (byte_end && state_reg == ST_RD_DATA) begin
        addr_reg <= addr_reg + 16'd1;
        if (rd_stop) begin
          shift_reg <= crc_nx; // see R12, R14
        end
      end else if (slot_go && state_reg == ST_WR_DATA
          && cnt_reg == 7'(BUF_BYTES * 8 - 1)) begin
        shift_reg <= crc_nx; // see R17
      end else if (slot_go && (state_reg == ST_ROM_CMD || state_reg == ST_MEM_CMD
          || state_reg == ST_WR_DATA || state_reg == ST_WR_PROGCMD)) begin
        shift_reg <= rx_byte;
      end
    end
  end

  // program pulse length
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_cnt_reg <= '0;
    end else if (state_reg != ST_WR_PULSE) begin
      prog_cnt_reg <= '0;
    end else if (vpp_on && prog_cnt_reg < PROG_LIM) begin
      prog_cnt_reg <= prog_cnt_reg + 32'd1;
    end
  end

  // eprom cells: erased to ones, programming only clears bits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < FIELD_BYTES; i++) begin
        mem_reg[i] <= MEM_ERASED; // see R26
      end
    end else if (fifo_out_ready && fifo_out_valid && in_field({8'h00, wr_idx})) begin
      mem_reg[wr_idx] <= mem_reg[wr_idx] & fifo_out_data; // see R19
    end
  end

  // bit for the next read slot
  always_comb begin
    tx_next.drive = 1'b0;
    tx_next.bit_val = 1'b1;
    case (state_reg)
      ST_SEARCH: begin
        tx_next.drive = (phase_reg != 2'd2);
        tx_next.bit_val = id_bit ^ phase_reg[0]; // see R3
      end
      ST_ADDR_CRC, ST_RD_CRC, ST_WR_CRC: begin
        tx_next.drive = 1'b1;
        tx_next.bit_val = shift_reg[cnt_reg[2:0]];
      end
      ST_RD_DATA, ST_WR_VERIFY: begin
        tx_next.drive = 1'b1;
        tx_next.bit_val = rd_byte[cnt_reg[2:0]]; // see R9, R22
      end
      ST_RD_ONES: begin
        tx_next.drive = 1'b1; // see R15
      end
      default: begin
        tx_next.drive = 1'b0;
      end
    endcase
  end

  // registered outputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx <= '{drive: 1'b0, bit_val: 1'b1};
      presence_req <= 1'b0;
    end else begin
      tx <= tx_next;
      presence_req <= bus_reset; // see R1
    end
  end

endmodule

// ---- logic/link_pkg.sv ----
// shared constants, types and states of the single-wire eprom command layer
package link_pkg;

  // command codes as seen on the line
  localparam logic [7:0] CMD_MATCH = 8'h55;
  localparam logic [7:0] CMD_SEARCH = 8'hF0;
  localparam logic [7:0] CMD_SKIP = 8'hCC;
  localparam logic [7:0] CMD_READ_PAGE = 8'hC3;
  localparam logic [7:0] CMD_READ_FIELD = 8'hF0;
  localparam logic [7:0] CMD_WRITE = 8'h0F;
  localparam logic [7:0] CMD_PROGRAM = 8'h5A;

  // memory geometry
  localparam int FIELD_BYTES = 192;
  localparam int PAGE_BYTES = 32;
  localparam int BUF_BYTES = 8;
  localparam int ID_BITS = 64;
  localparam logic [7:0] FIELD_LAST = 8'hBF;
  localparam logic [4:0] PAGE_LAST = 5'h1F;
  localparam logic [7:0] MEM_ERASED = 8'hFF;

  // crc x^8 + x^5 + x^4 + 1, bit reflected for lsb-first shifting
  localparam logic [7:0] CRC_POLY = 8'h8C;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // identity default; value is arbitrary
  localparam logic [63:0] DEFAULT_ID = 64'hA500_0000_1234_5601;

  // timing at the 125 MHz reference clock
  localparam int CLK_MHZ = 125;
  localparam int RESET_MIN_US = 480;
  localparam int RESET_CYCLES = RESET_MIN_US * CLK_MHZ;
  localparam int PROG_TIME_US = 2500;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;

  // one finished time slot from the slot layer
  typedef struct packed {
    logic valid;
    logic bit_val;
  } slot_in_t;

  // bit to present in the next read slot
  typedef struct packed {
    logic drive;
    logic bit_val;
  } slot_out_t;

  typedef enum logic [1:0] {OP_PAGE, OP_FIELD, OP_WRITE} op_t;

  typedef enum logic [4:0] {
    ST_IDLE, ST_PRESENCE, ST_ROM_CMD, ST_MATCH, ST_SEARCH, ST_MEM_CMD, ST_ADDR,
    ST_ADDR_CRC, ST_RD_DATA, ST_RD_CRC, ST_RD_ONES, ST_WR_DATA, ST_WR_CRC,
    ST_WR_PROGCMD, ST_WR_PULSE, ST_WR_APPLY, ST_WR_VERIFY, ST_IGNORE
  } state_t;

endpackage

// ---- logic/crc8_serial.sv ----
// bit-serial crc generator, lsb first
module crc8_serial import link_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // control
  input wire logic clr,
  input wire logic shift_en,
  input wire logic bit_in,
  // result now and after the pending bit
  output logic [7:0] crc,
  output logic [7:0] crc_nx
);

  // next value, so a caller can capture it in the same edge as the last bit
  always_comb begin
    crc_nx = {1'b0, crc[7:1]} ^ ((crc[0] ^ bit_in) ? CRC_POLY : 8'h00);
  end

  // clear wins over shift
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      crc <= CRC_INIT;
    end else if (clr) begin
      crc <= CRC_INIT;
    end else if (shift_en) begin
      crc <= crc_nx;
    end
  end

endmodule

// ---- logic/byte_fifo.sv ----
// small synchronous fifo with flush
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage, written only on a real push
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

// ---- testbench/one_wire_eprom_command_layer_props.sv ----
// port assertions of the single-wire eprom command layer
module one_wire_eprom_command_layer_props import link_pkg::*; #(
  parameter int RESET_CYCLES_P = RESET_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // slot layer side
  input wire logic line_level,
  input wire slot_in_t slot,
  input wire logic presence_done,
  input wire logic vpp_on,
  // device answers
  input wire logic presence_req,
  input wire slot_out_t tx,
  input wire logic selected
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [16:0] low_cnt_reg;

  // low run length, saturating so a stuck line never wraps to zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_reg <= '0;
    end else if (line_level) begin
      low_cnt_reg <= '0;
    end else if (!(&low_cnt_reg)) begin
      low_cnt_reg <= low_cnt_reg + 17'h1;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  pres_one_shot_a: assert property (presence_req |=> !presence_req)
    else $error("presence request held too long");
  pres_cause_a: assert property (presence_req |-> $past(line_level) &&
    $past(low_cnt_reg) >= RESET_CYCLES_P - 1) else $error("presence without long low");
  pres_answer_a: assert property ($rose(line_level) && !vpp_on &&
    low_cnt_reg >= RESET_CYCLES_P + 1 |-> ##[0:2] presence_req) else $error("no presence");
  pres_desel_a: assert property (presence_req |-> !selected)
    else $error("still selected at presence");
  pres_quiet_a: assert property (presence_req |=> !tx.drive [*8])
    else $error("driving after bus reset");
  prog_no_reset_a: assert property (vpp_on |-> !presence_req)
    else $error("bus reset taken during program pulse");
  prog_quiet_a: assert property (vpp_on |-> !tx.drive)
    else $error("driving during program pulse");
  sel_after_slot_a: assert property ($rose(selected) |-> $past(slot.valid) ||
    $past(slot.valid, 2) || $past(slot.valid, 3)) else $error("selected without a slot");
  desel_by_reset_a: assert property ($fell(selected) |-> presence_req)
    else $error("deselected without bus reset");

  cover property (presence_req);
  cover property ($rose(selected));
  cover property ($fell(vpp_on));
  cover property (slot.valid && tx.drive && !tx.bit_val);
endmodule

bind one_wire_eprom_command_layer one_wire_eprom_command_layer_props #(
  .RESET_CYCLES_P(RESET_CYCLES_P)
) one_wire_eprom_command_layer_props_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .line_level(line_level), .slot(slot),
  .presence_done(presence_done), .vpp_on(vpp_on), .presence_req(presence_req),
  .tx(tx), .selected(selected)
);

// ---- testbench/host_model.sv ----
// host side model: bus reset, time slots and program pulse on the wire
module host_model import link_pkg::*; #(
  parameter int RESET_LEN = 20
) (
  // clock
  input wire logic ref_clk,
  // towards the device
  output logic line_level,
  output slot_in_t slot,
  output logic presence_done,
  output logic vpp_on,
  // from the device
  input wire logic presence_req,
  input wire slot_out_t tx
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle line is pulled high
  initial begin
    line_level = 1'b1;
    slot = '0;
    presence_done = 1'b0;
    vpp_on = 1'b0;
  end

  // long low, then watch for presence; entered at a falling edge
  task automatic bus_reset(output logic seen);
    seen = 1'b0;
    line_level = 1'b0;
    repeat (RESET_LEN + 4) @(negedge ref_clk);
    line_level = 1'b1;
    repeat (4) begin
      @(negedge ref_clk);
      if (presence_req === 1'b1) seen = 1'b1;
    end
    presence_done = 1'b1;
    @(negedge ref_clk);
    presence_done = 1'b0;
    @(negedge ref_clk);
  endtask

  // one slot, wired and of host and device, four cycles apart
  task automatic slot_op(input logic w, output logic r);
    r = w & (tx.drive ? tx.bit_val : 1'b1);
    slot = '{valid: 1'b1, bit_val: r};
    @(negedge ref_clk);
    slot = '{valid: 1'b0, bit_val: ~r}; // stale level must not look valid
    repeat (3) @(negedge ref_clk);
  endtask

  // program pulse; line stays high, so no bus reset meanwhile
  task automatic prog(input int n);
    vpp_on = 1'b1;
    repeat (n) @(negedge ref_clk);
    vpp_on = 1'b0;
    repeat (12) @(negedge ref_clk);
  endtask
endmodule

// ---- testbench/one_wire_eprom_command_layer_tb_top.sv ----
// self-checking bench of the single-wire eprom command layer
module one_wire_eprom_command_layer_tb_top import link_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RESET_LEN = 20;
  localparam int PROG_LEN = 10;
  // identity of the device; value is arbitrary
  localparam logic [63:0] DEV_ID = 64'h3c5a_0f96_7e21_d4b8;
  logic ref_clk, rst_n, line_level, presence_done, vpp_on, presence_req, selected;
  slot_in_t slot;
  slot_out_t tx;
  logic rd_on, seen;
  logic [7:0] sh, ev;
  logic [7:0] mem [192];
  logic [7:0] exp_q [$];
  int nb, cyc, checks, n_mismatch;

  one_wire_eprom_command_layer #(
    .DEVICE_ID(DEV_ID), .RESET_CYCLES_P(RESET_LEN), .PROG_CYCLES_P(PROG_LEN)
  ) one_wire_eprom_command_layer_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .line_level(line_level), .slot(slot),
    .presence_done(presence_done), .vpp_on(vpp_on), .presence_req(presence_req),
    .tx(tx), .selected(selected)
  );
  host_model #(.RESET_LEN(RESET_LEN)) host_model_inst (
    .ref_clk(ref_clk), .line_level(line_level), .slot(slot),
    .presence_done(presence_done), .vpp_on(vpp_on), .presence_req(presence_req), .tx(tx)
  );

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  function automatic logic [7:0] crc_b(logic [7:0] c, logic [7:0] b);
    for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ b[i]) ? 8'h8c : 8'h00);
    return c;
  endfunction

  task automatic chk(input logic [7:0] e, input logic [7:0] s, input string nm);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) host_model_inst.slot_op(d[i], r);
  endtask

  // the watcher compares; this only opens the read window
  task automatic rd(input int n);
    logic r;
    rd_on = 1'b1;
    repeat (n * 8) host_model_inst.slot_op(1'b1, r);
    rd_on = 1'b0;
  endtask

  task automatic send_id(input logic [63:0] v);
    wr(CMD_MATCH);
    for (int b = 0; b < 8; b++) wr(v[b*8 +: 8]);
  endtask

  task automatic mem_read(input logic [7:0] cmd, input logic [7:0] a, input int n);
    logic [7:0] c;
    wr(cmd);
    wr(a);
    wr(8'h00);
    exp_q.push_back(crc_b(crc_b(crc_b(8'h00, cmd), a), 8'h00));
    c = 8'h00;
    for (int k = 0; k < n; k++) begin
      exp_q.push_back(mem[a]);
      c = crc_b(c, mem[a]);
      if ((cmd == CMD_READ_PAGE && a[4:0] == PAGE_LAST) || a == FIELD_LAST) begin
        exp_q.push_back(c);
        c = 8'h00;
      end
      a++;
    end
    if (a == 8'hc0) repeat (2) exp_q.push_back(8'hff);
    rd(exp_q.size());
  endtask

  task automatic mem_write(input logic [7:0] a);
    logic [7:0] c, d;
    wr(CMD_WRITE);
    wr(a);
    wr(8'h00);
    exp_q.push_back(crc_b(crc_b(crc_b(8'h00, CMD_WRITE), a), 8'h00));
    rd(1);
    c = 8'h00;
    for (int k = 0; k < 8; k++) begin
      d = 8'($urandom);
      wr(d);
      c = crc_b(c, d);
      mem[a + k] = mem[a + k] & d;
    end
    exp_q.push_back(c);
    rd(1);
    wr(CMD_PROGRAM);
    host_model_inst.prog(PROG_LEN + 2);
    for (int k = 0; k < 8; k++) exp_q.push_back(mem[a + k]);
    rd(8);
  endtask

  // rebuild each read byte from the answers, oldest note first
  always @(posedge ref_clk) begin
    if (rd_on && slot.valid) begin
      sh = {(tx.drive ? tx.bit_val : 1'b1), sh[7:1]};
      nb++;
      if (nb == 8) begin
        nb = 0;
        chk(exp_q.pop_front(), sh, "read byte");
      end
    end
  end

  // hang guard, well above the few thousand slots of the run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    rst_n = 1'b0;
    rd_on = 1'b0;
    nb = 0;
    sh = 8'h00;
    ev = 8'h00;
    foreach (mem[k]) mem[k] = MEM_ERASED;
    void'($urandom(32'h63e2));
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    chk(8'h00, {6'h00, selected, tx.drive}, "reset outputs");
    host_model_inst.bus_reset(seen);
    chk(8'h01, {7'h00, seen}, "presence");
    send_id(DEV_ID ^ 64'h8000_0000_0000_0000);
    chk(8'h00, {7'h00, selected}, "wrong match");
    wr(CMD_READ_FIELD);
    wr(8'h00);
    wr(8'h00);
    repeat (2) exp_q.push_back(8'hff);
    rd(2);
    $display("test unselected done");
    repeat (2) begin
      host_model_inst.bus_reset(seen);
      wr(CMD_SKIP);
      chk(8'h01, {7'h00, selected}, "skip select");
      mem_write(8'h10);
    end
    $display("test write done");
    host_model_inst.bus_reset(seen);
    send_id(DEV_ID);
    chk(8'h01, {7'h00, selected}, "match select");
    mem_read(CMD_READ_FIELD, 8'h08, 184);
    $display("test field read done");
    host_model_inst.bus_reset(seen);
    wr(CMD_SKIP);
    mem_read(CMD_READ_PAGE, 8'h0c, 52);
    host_model_inst.bus_reset(seen);
    chk(8'h00, {7'h00, selected}, "deselect");
    $display("test page read done");
    for (int p = 0; p < 2; p++) begin
      if (p == 1) host_model_inst.bus_reset(seen);
      wr(CMD_SEARCH);
      for (int i = 0; i < 64; i++) begin
        ev = {(p == 0 && i > 20) ? 2'b11 : {~DEV_ID[i], DEV_ID[i]}, ev[7:2]};
        if (i % 4 == 3) exp_q.push_back(ev);
      end
      for (int i = 0; i < 64; i++) begin
        rd_on = 1'b1;
        repeat (2) host_model_inst.slot_op(1'b1, seen);
        rd_on = 1'b0;
        host_model_inst.slot_op((p == 0 && i == 20) ? ~DEV_ID[i] : DEV_ID[i], seen);
      end
      chk(8'(p), {7'h00, selected}, "search select");
    end
    $display("test search done");
    chk(8'h00, 8'(exp_q.size()), "notes left");
    stop_test();
  end
endmodule
